// ---- hw/pbdma_map.vh ----
// Register offsets, field positions, reset values and timing counts for the burst DMA controller.
`ifndef PBDMA_MAP_VH
`define PBDMA_MAP_VH
`define PBDMA_OFF_SRC 12'h000
`define PBDMA_OFF_DST 12'h004
`define PBDMA_OFF_SETUP 12'h008
`define PBDMA_OFF_CTRL 12'h00C
`define PBDMA_OFF_COUNT 12'h010
`define PBDMA_OFF_STATE 12'h014
`define PBDMA_OFF_IST 12'h018
`define PBDMA_OFF_CUR_SRC 12'h01C
`define PBDMA_OFF_CUR_DST 12'h020
`define PBDMA_SETUP_MODE_LSB 0
`define PBDMA_SETUP_SRC_INC 3
`define PBDMA_SETUP_DST_INC 4
`define PBDMA_SETUP_TOGGLE 5
`define PBDMA_SETUP_MANCLR 6
`define PBDMA_SETUP_PINS 7
`define PBDMA_SETUP_EXTGATE 8
`define PBDMA_SETUP_BLEN_LSB 12
`define PBDMA_CTRL_START 0
`define PBDMA_CTRL_PAUSE 1
`define PBDMA_CTRL_ABORT 2
`define PBDMA_ST_BURST 0
`define PBDMA_ST_XFER 1
`define PBDMA_ST_BUSY 2
`define PBDMA_ST_PAUSED 3
`define PBDMA_ST_GATEWAIT 4
`define PBDMA_ST_BADMODE 5
`define PBDMA_SETUP_RESET 32'h00008018
`define PBDMA_MODE_SLV_WR 3'h0
`define PBDMA_MODE_SLV_RD 3'h1
`define PBDMA_MODE_INT_INT 3'h2
`define PBDMA_MODE_MRD 3'h4
`define PBDMA_MODE_MWR 3'h5
`define PBDMA_MODE_P2P 3'h6
`define PBDMA_MAX_BURST 4'h8
`define PBDMA_BEAT_NS 5
`define PBDMA_BEAT_CYC ((`PBDMA_BEAT_NS + 4) / 5)
`endif

// ---- hw/pbdma_ctrl.v ----
// Burst DMA controller of the PCI host interface with an APB register file.
`timescale 1ns/1ps
`include "pbdma_map.vh"
// Function
// [R1] Transfer length one to 16777215 dwords, in bursts.
// [R2] Burst size configurable one to eight dwords.
// [R3] Slave-read mode needs burst length two to eight.
// [R4] Final burst carries only the remaining dwords.
// [R5] Addresses advance by burst size or stay, separately.
// [R6] FIFO destination must be set not to advance.
// [R7] Mode 000b: master writes buffer, drained internally.
// [R8] Mode 001b: prefetch internal data for slave read.
// [R9] Mode 010b: internal read then internal write.
// [R10] Mode 100b: PCI master read, internal write.
// [R11] Mode 101b: internal read, PCI master write.
// [R12] Mode 110b: PCI read then PCI write.
// [R13] Reserved mode codes start no data movement.
// [R14] Odd start address issued as preceding even address.
// [R15] Odd master read fetches one extra dword.
// [R16] Odd master write masks first dword, one extra.
// [R17] Registers for addresses, increments, burst, transfer size.
// [R18] Start, pause, abort controls; status shows progress.
// [R19] Burst and transfer done as flag or toggle.
// [R20] Flags sticky; clear on read or by write.
// [R21] Events feed interrupt status; use flag form.
// [R22] Optional done pins for external logic.
// [R23] External gate pin starts and pauses between bursts.
// [R24] Clear done interrupts through burst state register.
// [R25] Pause holds addresses and count, then resumes.
module pbdma_ctrl (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // External pins
  input wire burst_gate_pin,
  output reg burst_done_pin,
  output reg transfer_done_pin,
  // Source side beat interface (PCI or internal as the mode says)
  output reg src_req,
  output reg src_pci,
  output reg [31:0] src_addr,
  input wire src_valid,
  input wire [31:0] src_data,
  // Destination side beat interface
  output reg dst_req,
  output reg dst_pci,
  output reg [31:0] dst_addr,
  output reg [31:0] dst_data,
  output reg [3:0] dst_be,
  input wire dst_ack,
  // Done indications toward the interrupt status register
  output reg burst_irq_flag,
  output reg transfer_irq_flag
);

////////////////////////////////////////////////////////////////////////////////
// Sequencer states, one-hot.
localparam [5:0] S_IDLE = 6'h01;
localparam [5:0] S_WAIT = 6'h02;
localparam [5:0] S_FILL = 6'h04;
localparam [5:0] S_DRAIN = 6'h08;
localparam [5:0] S_DONE = 6'h10;
localparam [5:0] S_PAUSE = 6'h20;

reg [31:0] src_base;
reg [31:0] dst_base;
reg [31:0] setup;
reg [23:0] xfer_len;
reg [31:0] cur_src;
reg [31:0] cur_dst;
reg [23:0] remain;
reg [5:0] state;
// One entry beyond the largest burst holds the padding dword of an odd read.
reg [31:0] buf_mem [0:8];
reg [3:0] fill_idx;
reg [3:0] drain_idx;
reg [3:0] beats;
reg [3:0] words;
reg [3:0] drain_n;
reg skip_first;
reg burst_flag;
reg xfer_flag;
reg burst_tgl;
reg xfer_tgl;
reg bad_mode;
reg pause_req;
reg [2:0] gate_sync;
reg gate_level;

wire [2:0] mode = setup[`PBDMA_SETUP_MODE_LSB +: 3];
wire [3:0] blen_cfg = setup[`PBDMA_SETUP_BLEN_LSB +: 4];
wire ext_gate = setup[`PBDMA_SETUP_EXTGATE];
wire src_is_pci = (mode == `PBDMA_MODE_MRD) || (mode == `PBDMA_MODE_P2P);
wire dst_is_pci = (mode == `PBDMA_MODE_MWR) || (mode == `PBDMA_MODE_P2P);
// Codes 3 and 7 are reserved and never start a transfer.
wire mode_ok = (mode != 3'h3) && (mode != 3'h7);
wire [3:0] blen = (blen_cfg == 4'h0) ? 4'h1 :
  (blen_cfg > `PBDMA_MAX_BURST) ? `PBDMA_MAX_BURST : blen_cfg;
// The last burst of a transfer carries only what remains.
wire [3:0] this_len = (remain < {20'h0, blen}) ? remain[3:0] : blen;
// Only the PCI side carries the 64-bit alignment restriction.
wire src_odd = src_is_pci && cur_src[2];
wire dst_odd = dst_is_pci && cur_dst[2];
wire acc = psel && penable;
wire wr = acc && pwrite;
wire rd = acc && !pwrite;
wire hit_state = (paddr == `PBDMA_OFF_STATE);
wire hit_ist = (paddr == `PBDMA_OFF_IST);
// An unmapped offset answers with an error together with ready.
wire known = (paddr == `PBDMA_OFF_SRC) || (paddr == `PBDMA_OFF_DST) ||
  (paddr == `PBDMA_OFF_SETUP) || (paddr == `PBDMA_OFF_CTRL) ||
  (paddr == `PBDMA_OFF_COUNT) || hit_state || hit_ist ||
  (paddr == `PBDMA_OFF_CUR_SRC) || (paddr == `PBDMA_OFF_CUR_DST);
wire start_wr = wr && (paddr == `PBDMA_OFF_CTRL) &&
  pwdata[`PBDMA_CTRL_START];
wire abort_wr = wr && (paddr == `PBDMA_OFF_CTRL) &&
  pwdata[`PBDMA_CTRL_ABORT];
wire clr_rd = rd && !setup[`PBDMA_SETUP_MANCLR] && (hit_state || hit_ist);
wire clr_b = clr_rd || (wr && hit_state && pwdata[`PBDMA_ST_BURST]); // R24
wire clr_x = clr_rd || (wr && hit_state && pwdata[`PBDMA_ST_XFER]); // R24
wire last_fill = (fill_idx == beats - 4'h1);
wire last_drain = (drain_idx == drain_n - 4'h1);
// The fetch address runs one beat ahead once a beat is taken, so the far
// side never answers the next request with the previous address.
wire [3:0] next_fill = fill_idx + {3'h0, src_valid && state == S_FILL};
// Every beat skips the padding dword of an odd read; later beats step back for the
// masked first beat of an odd write; that masked beat reads the same entry as the first real beat.
wire [3:0] drain_pos = drain_idx + {3'h0, skip_first} -
  {3'h0, dst_odd && drain_idx != 4'h0};
wire burst_end = (state == S_DRAIN) && dst_ack && last_drain;
wire xfer_end = burst_end && (remain == {20'h0, words});
wire go_ok = !ext_gate || gate_level;

////////////////////////////////////////////////////////////////////////////////
// Gate pin filter: a change is taken once the second and third stages agree.
// A glitch shorter than two clocks never reaches the sequencer; the price
// is a start delay of a few cycles after the pin rises.
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    gate_sync <= 3'h0;
    gate_level <= 1'b0;
  end else begin
    gate_sync <= {gate_sync[1:0], burst_gate_pin};
    if (gate_sync[1] == gate_sync[2])
      gate_level <= gate_sync[2];
  end
end

////////////////////////////////////////////////////////////////////////////////
// Register writes.
// Set-up writes are ignored while a transfer runs, so a half-changed
// set-up never steers a burst in flight.
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    src_base <= 32'h00000000;
    dst_base <= 32'h00000000;
    setup <= `PBDMA_SETUP_RESET;
    xfer_len <= 24'h000001;
  end else if (wr && (state == S_IDLE)) begin
    case (paddr)
      `PBDMA_OFF_SRC: src_base <= {pwdata[31:2], 2'b00};
      `PBDMA_OFF_DST: dst_base <= {pwdata[31:2], 2'b00};
      `PBDMA_OFF_SETUP: setup <= pwdata; // R17
      `PBDMA_OFF_COUNT: xfer_len <= pwdata[23:0]; // R1
      default: ;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// Bus answer: every access completes in its first access cycle.
// Read data is registered in the setup cycle so that it stands in the
// access cycle, where the master takes it.
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    prdata <= 32'h00000000;
    pready <= 1'b0;
    pslverr <= 1'b0;
  end else begin
    pready <= psel && !penable;
    pslverr <= psel && !penable && !known;
    prdata <= 32'h00000000;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `PBDMA_OFF_SRC: prdata <= src_base;
        `PBDMA_OFF_DST: prdata <= dst_base;
        `PBDMA_OFF_SETUP: prdata <= setup;
        `PBDMA_OFF_COUNT: prdata <= {8'h00, remain}; // R18
        `PBDMA_OFF_STATE: prdata <= {26'h0, bad_mode, // R18
          (state == S_WAIT), (state == S_PAUSE), (state != S_IDLE),
          setup[`PBDMA_SETUP_TOGGLE] ? xfer_tgl : xfer_flag,
          setup[`PBDMA_SETUP_TOGGLE] ? burst_tgl : burst_flag}; // R19
        `PBDMA_OFF_IST: prdata <= {30'h0, xfer_flag, burst_flag}; // R21
        `PBDMA_OFF_CUR_SRC: prdata <= cur_src;
        `PBDMA_OFF_CUR_DST: prdata <= cur_dst;
        default: prdata <= 32'h00000000;
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Transfer sequencer.
// Abort wins over every other control and leaves the flags alone, so
// software can still see which bursts had finished.
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    state <= S_IDLE;
    cur_src <= 32'h00000000;
    cur_dst <= 32'h00000000;
    remain <= 24'h000000;
    fill_idx <= 4'h0;
    drain_idx <= 4'h0;
    beats <= 4'h0;
    words <= 4'h0;
    drain_n <= 4'h0;
    skip_first <= 1'b0;
    bad_mode <= 1'b0;
    pause_req <= 1'b0;
  end else if (abort_wr) begin
    state <= S_IDLE; // R18
    pause_req <= 1'b0;
  end else begin
    if (wr && (paddr == `PBDMA_OFF_CTRL))
      pause_req <= pwdata[`PBDMA_CTRL_PAUSE]; // R18
    case (state)
      S_IDLE: begin
        // A zero length or a reserved mode leaves the sequencer idle.
        if (start_wr || (ext_gate && gate_level)) begin // R23
          if (!mode_ok || xfer_len == 24'h0) begin
            bad_mode <= !mode_ok; // R13
          end else begin
            bad_mode <= 1'b0;
            cur_src <= src_base;
            cur_dst <= dst_base;
            remain <= xfer_len; // R1
            state <= S_WAIT;
          end
        end
      end
      S_WAIT: begin
        // A pause only ever lands here, between bursts.
        if (pause_req || !go_ok) begin
          state <= S_PAUSE; // R25
        end else begin
          words <= this_len; // R2 R4
          // Fill and drain counts differ when only one end is odd.
          beats <= this_len + {3'h0, src_odd}; // R15
          drain_n <= this_len + {3'h0, dst_odd}; // R16
          skip_first <= src_odd; // R15
          fill_idx <= 4'h0;
          drain_idx <= 4'h0;
          state <= S_FILL;
        end
      end
      S_PAUSE: begin
        // Addresses and the remaining count stay as they are here.
        if (!pause_req && go_ok)
          state <= S_WAIT; // R25 R23
      end
      // At most one beat per cycle; each valid pulse is one dword.
      S_FILL: begin
        if (src_valid) begin
          fill_idx <= fill_idx + 4'h1;
          if (last_fill)
            state <= S_DRAIN;
        end
      end
      S_DRAIN: begin
        if (dst_ack) begin
          drain_idx <= drain_idx + 4'h1;
          if (last_drain) begin
            // The padding dword is no part of the step, so the next burst
            // starts right after the last real dword.
            if (setup[`PBDMA_SETUP_SRC_INC])
              cur_src <= cur_src + {26'h0, words, 2'b00}; // R5
            if (setup[`PBDMA_SETUP_DST_INC])
              cur_dst <= cur_dst + {26'h0, words, 2'b00}; // R5 R6
            remain <= remain - {20'h0, words};
            state <= xfer_end ? S_DONE : S_WAIT;
          end
        end
      end
      S_DONE: state <= S_IDLE;
      default: state <= S_IDLE;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// Staging buffer; an odd PCI read stores the padding dword and skips it.
// It has no reset: every entry that a burst drains was written earlier
// in the same burst.
always @(posedge pclk) begin
  if (state == S_FILL && src_valid)
    buf_mem[fill_idx] <= src_data; // R9 R10 R11 R12
end

// Beat interface outputs.
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    src_req <= 1'b0;
    src_pci <= 1'b0;
    src_addr <= 32'h00000000;
    dst_req <= 1'b0;
    dst_pci <= 1'b0;
    dst_addr <= 32'h00000000;
    dst_data <= 32'h00000000;
    dst_be <= 4'h0;
  end else begin
    src_req <= (state == S_FILL) && !(src_valid && last_fill);
    src_pci <= src_is_pci; // R7 R8 R10 R12
    src_addr <= {cur_src[31:3], cur_src[2] && !src_is_pci, 2'b00} +
      {26'h0, next_fill, 2'b00}; // R14
    dst_req <= (state == S_DRAIN) && !burst_end;
    dst_pci <= dst_is_pci; // R7 R8 R11 R12
    dst_addr <= {cur_dst[31:3], cur_dst[2] && !dst_is_pci, 2'b00} +
      {26'h0, drain_idx, 2'b00}; // R14
    dst_data <= buf_mem[drain_pos]; // R15 R16
    dst_be <= (dst_odd && drain_idx == 4'h0) ? 4'h0 : 4'hF; // R16
  end
end

////////////////////////////////////////////////////////////////////////////////
// Completion flags: a new event wins over a clear in the same cycle.
// The pins follow the event in the cycle that sets the flag, so external
// logic sees no extra delay.
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    burst_flag <= 1'b0;
    xfer_flag <= 1'b0;
    burst_tgl <= 1'b0;
    xfer_tgl <= 1'b0;
    burst_done_pin <= 1'b0;
    transfer_done_pin <= 1'b0;
    burst_irq_flag <= 1'b0;
    transfer_irq_flag <= 1'b0;
  end else begin
    // No flag is set in toggle form: one left over would raise the
    // interrupt later, when software goes back to flag form.
    if (burst_end && !setup[`PBDMA_SETUP_TOGGLE])
      burst_flag <= 1'b1; // R19 R20
    else if (clr_b)
      burst_flag <= 1'b0; // R20
    if (xfer_end && !setup[`PBDMA_SETUP_TOGGLE])
      xfer_flag <= 1'b1; // R19 R20
    else if (clr_x)
      xfer_flag <= 1'b0; // R20
    if (burst_end)
      burst_tgl <= !burst_tgl; // R19
    if (xfer_end)
      xfer_tgl <= !xfer_tgl; // R19
    burst_done_pin <= setup[`PBDMA_SETUP_PINS] &&
      (setup[`PBDMA_SETUP_TOGGLE] ? (burst_tgl ^ burst_end) :
      (burst_flag || burst_end)); // R22
    transfer_done_pin <= setup[`PBDMA_SETUP_PINS] &&
      (setup[`PBDMA_SETUP_TOGGLE] ? (xfer_tgl ^ xfer_end) :
      (xfer_flag || xfer_end)); // R22
    // Toggle form cannot drive a level interrupt, so it is held off.
    burst_irq_flag <= !setup[`PBDMA_SETUP_TOGGLE] &&
      ((burst_flag && !clr_b) || burst_end); // R21
    transfer_irq_flag <= !setup[`PBDMA_SETUP_TOGGLE] &&
      ((xfer_flag && !clr_x) || xfer_end); // R21
  end
end

endmodule // pbdma_ctrl

// ---- dv/pbdma_ctrl_asserts.sv ----
// Port-level assertions for the burst DMA controller.
`timescale 1ns/1ps
module pbdma_ctrl_asserts (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  // Beats and done flags
  input wire src_req,
  input wire src_pci,
  input wire [31:0] src_addr,
  input wire dst_req,
  input wire dst_ack,
  input wire burst_irq_flag,
  input wire transfer_irq_flag
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  property p_ready_next; s_setup |=> s_access ##0 pready; endproperty
  a_ready_next: assert property (p_ready_next)
    else $error("no pready after setup");
  property p_ready_access; pready |-> s_access; endproperty
  a_ready_access: assert property (p_ready_access)
    else $error("pready outside access");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("pslverr without pready");
  // A burst is filled completely before any of it is drained.
  property p_fill_drain; !(src_req && dst_req); endproperty
  a_fill_drain: assert property (p_fill_drain)
    else $error("fill and drain overlap");
  // Flags may only drop at an APB access, which is where clears happen.
  property p_burst_hold;
    burst_irq_flag && !penable |=> burst_irq_flag;
  endproperty
  a_burst_hold: assert property (p_burst_hold)
    else $error("burst flag dropped");
  property p_xfer_hold;
    transfer_irq_flag && !penable |=> transfer_irq_flag;
  endproperty
  a_xfer_hold: assert property (p_xfer_hold)
    else $error("transfer flag dropped");
  property p_burst_cause;
    $rose(burst_irq_flag) |-> $past(dst_req && dst_ack);
  endproperty
  a_burst_cause: assert property (p_burst_cause)
    else $error("burst flag without last beat");
  property p_src_even;
    $rose(src_req) && src_pci |-> !src_addr[2];
  endproperty
  a_src_even: assert property (p_src_even)
    else $error("odd PCI start address");
endmodule // pbdma_ctrl_asserts

bind pbdma_ctrl pbdma_ctrl_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .src_req(src_req),
  .src_pci(src_pci), .src_addr(src_addr), .dst_req(dst_req),
  .dst_ack(dst_ack), .burst_irq_flag(burst_irq_flag),
  .transfer_irq_flag(transfer_irq_flag)
);

// ---- dv/pbdma_beat_model.sv ----
// Far-side endpoint that answers source fetches and destination writes.
`timescale 1ns/1ps
module pbdma_beat_model (
  // Clock and pace
  input wire pclk,
  input wire presetn,
  input wire slow,
  // Source side
  input wire src_req,
  input wire [31:0] src_addr,
  output reg src_valid,
  output reg [31:0] src_data,
  // Destination side
  input wire dst_req,
  input wire [31:0] dst_addr,
  input wire [31:0] dst_data,
  input wire [3:0] dst_be,
  output reg dst_ack
);
  int src_n = 0;
  int dst_n = 0;
  logic [31:0] sq[$];
  logic [31:0] dq[$];
  logic [31:0] vq[$];
  logic [3:0] bq[$];
  reg [1:0] pace;
  // Idle data changes every cycle so a late sample never passes.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_valid <= 1'b0;
      dst_ack <= 1'b0;
      pace <= 2'h0;
      src_data <= 32'h0;
    end else begin
      pace <= pace + 2'h1;
      src_valid <= src_req && !src_valid && (!slow || pace == 2'h3);
      dst_ack <= dst_req && !dst_ack && (!slow || pace == 2'h3);
      src_data <= ~src_addr ^ (src_req ? 32'h0 : {30'h0, pace});
      if (src_req && src_valid) begin
        src_n <= src_n + 1;
        sq.push_back(src_addr);
      end
      if (dst_req && dst_ack) begin
        dst_n <= dst_n + 1;
        dq.push_back(dst_addr);
        vq.push_back(dst_data);
        bq.push_back(dst_be);
      end
    end
  end
endmodule // pbdma_beat_model

// ---- dv/pbdma_ctrl_test.sv ----
// Self-checking bench of the burst DMA controller.
`timescale 1ns/1ps
`include "pbdma_map.vh"
module pbdma_ctrl_test;
  typedef struct {
    logic [2:0] m;
    logic [3:0] bl;
    logic [31:0] len;
    logic [31:0] a;
    int ns;
    int nd;
  } pbdma_row_t;
  pbdma_row_t rows[8];
  reg pclk, presetn, psel, penable, pwrite, burst_gate_pin, slow, err, t;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd;
  reg [1:0] pe;
  wire [31:0] prdata, src_addr, src_data, dst_addr, dst_data;
  wire [3:0] dst_be;
  wire pready, pslverr, burst_done_pin, transfer_done_pin, src_req;
  wire src_pci, src_valid, dst_req, dst_pci, dst_ack;
  wire burst_irq_flag, transfer_irq_flag;
  integer fail_count = 0, check_count = 0, cyc = 0, i, s0, d0;
  pbdma_ctrl u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .burst_gate_pin(burst_gate_pin),
    .burst_done_pin(burst_done_pin),
    .transfer_done_pin(transfer_done_pin), .src_req(src_req),
    .src_pci(src_pci), .src_addr(src_addr), .src_valid(src_valid),
    .src_data(src_data), .dst_req(dst_req), .dst_pci(dst_pci),
    .dst_addr(dst_addr), .dst_data(dst_data), .dst_be(dst_be),
    .dst_ack(dst_ack), .burst_irq_flag(burst_irq_flag),
    .transfer_irq_flag(transfer_irq_flag)
  );
  pbdma_beat_model u_peer (
    .pclk(pclk), .presetn(presetn), .slow(slow), .src_req(src_req),
    .src_addr(src_addr), .src_valid(src_valid), .src_data(src_data),
    .dst_req(dst_req), .dst_addr(dst_addr), .dst_data(dst_data),
    .dst_be(dst_be), .dst_ack(dst_ack)
  );
  ////////////////////////////////////////
  task check(input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // The trailing idle edge lets the access edge's updates land first.
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task run(input [31:0] setup, input [31:0] a, input [31:0] len);
    begin
      s0 = u_peer.src_n;
      d0 = u_peer.dst_n;
      apb(1'b1, `PBDMA_OFF_SRC, a);
      apb(1'b1, `PBDMA_OFF_DST, a + 32'h100);
      apb(1'b1, `PBDMA_OFF_SETUP, setup);
      apb(1'b1, `PBDMA_OFF_COUNT, len);
      if (!setup[8]) apb(1'b1, `PBDMA_OFF_CTRL, 32'h1);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      wrap_up;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, burst_gate_pin, slow} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    rows[0] = '{3'h2, 4'h3, 7, 32'h100, 7, 7};
    rows[1] = '{3'h4, 4'h2, 4, 32'h104, 6, 4};
    rows[2] = '{3'h5, 4'h2, 4, 32'h104, 4, 6};
    rows[3] = '{3'h6, 4'h8, 8, 32'h100, 8, 8};
    rows[4] = '{3'h0, 4'h8, 5, 32'h100, 5, 5};
    rows[5] = '{3'h1, 4'h2, 3, 32'h100, 3, 3};
    rows[6] = '{3'h3, 4'h2, 4, 32'h100, 0, 0};
    rows[7] = '{3'h7, 4'h2, 4, 32'h100, 0, 0};
    repeat (6) @(posedge pclk);
    check({src_req, dst_req, pready, burst_done_pin, transfer_irq_flag}, 0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `PBDMA_OFF_SETUP, 32'h0);
    check(rd, `PBDMA_SETUP_RESET);
    apb(1'b0, 12'h100, 32'h0);
    check(err, 1);
    $display("register access done");
    for (i = 0; i < 8; i = i + 1) begin
      run({16'h0, rows[i].bl, 12'h098} | rows[i].m, rows[i].a, rows[i].len);
      while (u_peer.dst_n < d0 + rows[i].nd) @(posedge pclk);
      repeat (20) @(posedge pclk);
      check(u_peer.src_n - s0, rows[i].ns);
      check(u_peer.dst_n - d0, rows[i].nd);
      check(transfer_done_pin, rows[i].nd > 0);
      check(burst_done_pin, rows[i].nd > 0);
      pe = {rows[i].m == 3'h4 || rows[i].m == 3'h6,
        rows[i].m == 3'h5 || rows[i].m == 3'h6};
      check({src_pci, dst_pci}, pe);
      if (rows[i].m == 3'h4) check(u_peer.sq[s0], 32'h100);
      if (rows[i].m == 3'h5) check(u_peer.bq[d0], 0);
      apb(1'b0, `PBDMA_OFF_IST, 32'h0);
      check(rd[1:0], (rows[i].nd > 0) ? 3 : 0);
      check(burst_irq_flag, 0);
      apb(1'b0, `PBDMA_OFF_STATE, 32'h0);
      check(rd[5], rows[i].nd == 0);
      $display("row %0d done", i);
    end
    // Source advances, destination stays as a FIFO port would need.
    run(32'h00002088 | `PBDMA_MODE_INT_INT, 32'h100, 4);
    while (u_peer.dst_n < d0 + 4) @(posedge pclk);
    repeat (20) @(posedge pclk);
    check(u_peer.sq[s0 + 2], 32'h108);
    check(u_peer.dq[d0 + 2], 32'h200);
    check(u_peer.vq[d0], ~32'h100);
    check(u_peer.vq[d0 + 1], ~32'h104);
    apb(1'b0, `PBDMA_OFF_IST, 32'h0);
    run(32'h000010D8 | `PBDMA_MODE_INT_INT, 32'h100, 1);
    while (u_peer.dst_n < d0 + 1) @(posedge pclk);
    repeat (20) @(posedge pclk);
    apb(1'b0, `PBDMA_OFF_IST, 32'h0);
    check(transfer_irq_flag, 1);
    apb(1'b1, `PBDMA_OFF_STATE, 32'h3);
    check({burst_irq_flag, transfer_irq_flag}, 0);
    run(32'h000010B8 | `PBDMA_MODE_INT_INT, 32'h100, 1);
    t = transfer_done_pin;
    while (u_peer.dst_n < d0 + 1) @(posedge pclk);
    repeat (20) @(posedge pclk);
    check(transfer_done_pin, !t);
    check(transfer_irq_flag, 0);
    $display("flag forms done");
    slow <= 1'b1;
    run(32'h00008098 | `PBDMA_MODE_INT_INT, 32'h100, 64);
    repeat (30) @(posedge pclk);
    apb(1'b1, `PBDMA_OFF_CTRL, 32'h4);
    repeat (10) @(posedge pclk);
    s0 = u_peer.src_n + u_peer.dst_n;
    repeat (100) @(posedge pclk);
    check(u_peer.src_n + u_peer.dst_n, s0);
    apb(1'b0, `PBDMA_OFF_STATE, 32'h0);
    check(rd[2], 0);
    slow <= 1'b0;
    $display("abort done");
    run(32'h00004198 | `PBDMA_MODE_INT_INT, 32'h100, 8);
    repeat (20) @(posedge pclk);
    check(u_peer.src_n, s0);
    burst_gate_pin <= 1'b1;
    while (u_peer.src_n == s0) @(posedge pclk);
    burst_gate_pin <= 1'b0;
    repeat (40) @(posedge pclk);
    check(u_peer.dst_n - d0, 4);
    apb(1'b0, `PBDMA_OFF_COUNT, 32'h0);
    check(rd, 4);
    burst_gate_pin <= 1'b1;
    while (u_peer.dst_n < d0 + 8) @(posedge pclk);
    check(u_peer.dq[d0 + 4], 32'h210);
    $display("gate done");
    wrap_up;
  end
endmodule // pbdma_ctrl_test
